// ---- logic/ir_array_master.sv ----
// Master end of the pixel-array serial link: runs one command at a time,
// makes the serial clock by dividing sys_clk, and returns read words.
// Assumes the slave sits on the device modport of the same interface.
`include "ir_link_defs.svh"
`default_nettype none

module ir_array_master #(
  parameter int unsigned QUARTER_CYC = `SCL_QUARTER_CYC,
  parameter logic [6:0]  ARRAY_ADDR  = `ARRAY_ADDR
) (
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  ir_link_if.host                     link,
  input  wire logic                   cmd_valid,
  input  wire ir_link_pkg::cmd_kind_t cmd_kind,
  input  wire logic [15:0]            cmd_word,
  input  wire logic [7:0]             cmd_start_addr,
  input  wire logic [7:0]             cmd_step,
  input  wire logic [7:0]             cmd_count,
  output logic                        cmd_ready,
  output logic                        rd_valid,
  output logic [15:0]                 rd_word,
  output logic                        done,
  output logic                        nack_seen
);
  ir_link_pkg::host_state_t state_reg;
  ir_link_pkg::cmd_kind_t   kind_reg;

  logic [15:0] word_reg;
  logic [7:0]  sa_reg;
  logic [7:0]  st_reg;
  logic [7:0]  cnt_reg;
  logic [3:0]  step_reg;
  logic [1:0]  q_reg;
  logic [7:0]  div_reg;
  logic [3:0]  bit_reg;
  logic [8:0]  rx_reg;
  logic [8:0]  left_reg;
  logic [7:0]  lo_reg;
  logic        scl_oe_reg;
  logic        sda_oe_reg;
  logic        sda_s;
  logic        p_cond;
  logic [3:0]  p_scl;
  logic [3:0]  p_sda;
  logic [8:0]  p_tx;

  assign link.scl_o    = 1'b0;
  assign link.m_sda_o  = 1'b0;
  assign link.scl_oe   = scl_oe_reg;
  assign link.m_sda_oe = sda_oe_reg;

  pin_sync #(
    .W (1)
  ) u_sda (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (link.sda),
    .q       (sda_s)
  );

  wire        is_rd   = kind_reg == ir_link_pkg::K_READ;
  wire [7:0]  key     = kind_reg == ir_link_pkg::K_CFG ? `CFG_KEY : `TRIM_KEY;
  wire [7:0]  op      = kind_reg == ir_link_pkg::K_CFG ? `OP_CFG : `OP_TRIM;
  wire [3:0]  stop_st = is_rd ? `STEP_RD_STOP : `STEP_ROW_END;
  wire        tick    = div_reg == 8'(QUARTER_CYC - 1);
  wire        last_q  = tick & (q_reg == 2'h3);
  wire        act_end = last_q & (p_cond | bit_reg == 4'h8);
  wire [8:0]  rx_full = {rx_reg[7:0], sda_s};
  wire        reading = is_rd & step_reg == `STEP_READS;

  // Step plan: framing patterns per quarter (q3..q0), or a byte plus ack slot
  always_comb begin
    p_cond = 1'b0;
    p_scl  = 4'b1110;
    p_sda  = 4'b0011;
    p_tx   = 9'h1FF;
    if (step_reg == 4'h0 | (is_rd & step_reg == 4'h6)) begin
      p_cond = 1'b1;
    end else if (step_reg == stop_st) begin
      p_cond = 1'b1;
      p_scl  = 4'b1110;
      p_sda  = 4'b1100;
    end else begin
      case (step_reg)
        4'h1: p_tx = {ARRAY_ADDR, 1'b0, 1'b1};
        4'h2: p_tx = {is_rd ? `OP_READ : op, 1'b1};
        4'h3: p_tx = {is_rd ? sa_reg : 8'(word_reg[7:0] - key), 1'b1};
        4'h4: p_tx = {is_rd ? st_reg : word_reg[7:0], 1'b1};
        4'h5: p_tx = {is_rd ? cnt_reg : 8'(word_reg[15:8] - key), 1'b1};
        4'h6: p_tx = {word_reg[15:8], 1'b1};
        4'h7: p_tx = {ARRAY_ADDR, 1'b1, 1'b1};
        4'h8: p_tx = {8'hFF, left_reg == 9'h001};
        default: p_tx = 9'h1FF;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst | state_reg == ir_link_pkg::H_IDLE | tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg  <= ir_link_pkg::H_IDLE;
      kind_reg   <= ir_link_pkg::K_READ;
      {word_reg, sa_reg, st_reg, cnt_reg} <= 40'h00_0000_0000;
      {step_reg, q_reg, bit_reg} <= 10'h000;
      {rx_reg, left_reg, lo_reg} <= 26'h000_0000;
      {scl_oe_reg, sda_oe_reg}   <= 2'b00;
      {cmd_ready, rd_valid, done, nack_seen} <= 4'b1000;
      rd_word    <= 16'h0000;
    end else begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (state_reg == ir_link_pkg::H_IDLE) begin
        if (cmd_valid) begin
          state_reg <= ir_link_pkg::H_RUN;
          cmd_ready <= 1'b0;
          nack_seen <= 1'b0;
          kind_reg  <= cmd_kind;
          word_reg  <= cmd_word;
          sa_reg    <= cmd_start_addr;
          st_reg    <= cmd_step;
          cnt_reg   <= cmd_count;
          left_reg  <= {cmd_count, 1'b0};
          {step_reg, q_reg, bit_reg} <= 10'h000;
        end
      end else if (tick) begin
        q_reg <= q_reg + 2'h1;
        // Clock and data move in different quarters, except the stop step's first quarter, which pulls both low
        if (p_cond) begin
          scl_oe_reg <= ~p_scl[q_reg];
          sda_oe_reg <= ~p_sda[q_reg];
        end else begin
          scl_oe_reg <= q_reg < 2'h2;
          if (q_reg == 2'h1) sda_oe_reg <= ~p_tx[4'h8 - bit_reg];
        end
        if (last_q & ~p_cond) begin
          rx_reg  <= rx_full;
          bit_reg <= bit_reg + 4'h1;
        end
        if (act_end) begin
          bit_reg  <= 4'h0;
          step_reg <= step_reg + 4'h1;
          if (step_reg == stop_st) begin
            state_reg <= ir_link_pkg::H_IDLE;
            cmd_ready <= 1'b1;
            done      <= 1'b1;
          end else if (reading) begin
            left_reg <= left_reg - 9'h001;
            lo_reg   <= rx_full[8:1];
            rd_word  <= {rx_full[8:1], lo_reg};
            rd_valid <= left_reg[0] == 1'b1;
            if (left_reg != 9'h001) step_reg <= step_reg;
          end else if (~p_cond & rx_full[0]) begin
            nack_seen <= 1'b1;
            step_reg  <= stop_st;
          end else if (is_rd & step_reg == 4'h7 & cnt_reg == 8'h00) begin
            step_reg <= `STEP_RD_STOP;
          end
        end
      end
    end
  end
endmodule : ir_array_master

`default_nettype wire

// ---- logic/ir_array_slave.sv ----
// Slave end of the pixel-array serial link: bit engine, command decoder,
// result RAM, checked setup and trim registers, frame timer.
// Assumes a bus master on the other modport and a measurement engine that
// fills the RAM after each frame_start pulse.
`include "ir_link_defs.svh"
`default_nettype none

module ir_array_slave #(
  parameter int unsigned STARTUP_CYC    = `STARTUP_CYC,
  parameter int unsigned FRAME_BASE_CYC = `FRAME_BASE_CYC,
  parameter logic [6:0]  ARRAY_ADDR     = `ARRAY_ADDR,
  parameter logic [6:0]  STORE_ADDR     = `STORE_ADDR
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  ir_link_if.device        link,
  input  wire logic        meas_we,
  input  wire logic [7:0]  meas_addr,
  input  wire logic [15:0] meas_data,
  input  wire logic [15:0] ambient_temperature_result,
  output logic             frame_start,
  output logic             startup_done,
  output logic [15:0]      frame_setup_word,
  output logic [15:0]      oscillator_tune_value
);
  ir_link_pkg::slave_state_t state_reg;

  logic [1:0]  pin_q;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic [31:0] boot_cnt_reg;
  logic [31:0] frame_cnt_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic        sda_oe_reg;
  logic        rw_reg;
  logic        sel_reg;
  logic        mack_reg;
  logic [2:0]  idx_reg;
  logic [7:0]  opcode_reg;
  logic [7:0]  chk_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  step_reg;
  logic [7:0]  left_reg;
  logic        hi_reg;
  logic [15:0] ram [256];

  // Only the data line is ever driven; the clock is never touched
  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = sda_oe_reg;

  pin_sync #(
    .W (2)
  ) u_pins (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       ({link.scl, link.sda}),
    .q       (pin_q)
  );

  wire scl_s      = pin_q[1];
  wire sda_s      = pin_q[0];
  wire scl_rise   = scl_s & ~scl_d_reg;
  wire scl_fall   = ~scl_s & scl_d_reg;
  // Data edges with the clock steady high are framing, not data
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire byte_in    = scl_fall & (bit_cnt_reg == 4'h8);
  wire hit_array  = shift_reg[7:1] == ARRAY_ADDR;
  wire addr_hit   = hit_array | (shift_reg[7:1] == STORE_ADDR);
  wire addr_ok    = (state_reg == ir_link_pkg::S_ADDR) & byte_in & addr_hit;
  wire byte_done  = (state_reg == ir_link_pkg::S_RX) & byte_in & sel_reg;
  wire tx_load    = scl_fall & ((state_reg == ir_link_pkg::S_ACK & rw_reg) |
                                (state_reg == ir_link_pkg::S_MACK & mack_reg));

  wire is_read    = opcode_reg == `OP_READ;
  wire is_cfg     = opcode_reg == `OP_CFG;
  wire is_trim    = opcode_reg == `OP_TRIM;
  wire [7:0] key  = is_cfg ? `CFG_KEY : `TRIM_KEY;
  wire chk_ok     = 8'(chk_reg + key) == shift_reg;
  wire pair_end   = byte_done & (idx_reg == 3'h2 | idx_reg == 3'h4) & chk_ok;
  wire set_lo     = pair_end & (idx_reg == 3'h2);
  wire [15:0] cur_word = (ptr_reg == `CFG_WORD)  ? frame_setup_word :
                         (ptr_reg == `TRIM_WORD) ? oscillator_tune_value : ram[ptr_reg];
  wire [7:0] tx_byte = (~sel_reg | left_reg == 8'h00) ? `IDLE_BYTE :
                       hi_reg ? cur_word[15:8] : cur_word[7:0];
  wire [31:0] frame_len = FRAME_BASE_CYC << frame_setup_word[`RATE_MSB:`RATE_LSB];
  wire frame_tick = startup_done & (frame_cnt_reg >= frame_len - 32'd1);

  // Startup hold-off; bus is ignored until it expires
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      boot_cnt_reg <= 32'h0000_0000;
      startup_done <= 1'b0;
    end else if (!startup_done) begin
      boot_cnt_reg <= boot_cnt_reg + 32'd1;
      startup_done <= boot_cnt_reg == STARTUP_CYC - 1;
    end
  end

  // Continuous frames; a faster rate cuts an overlong frame short at once
  always_ff @(posedge sys_clk) begin
    if (srst | !startup_done) begin
      frame_cnt_reg <= 32'h0000_0000;
      frame_start   <= 1'b0;
    end else begin
      frame_cnt_reg <= frame_tick ? 32'h0000_0000 : frame_cnt_reg + 32'd1;
      frame_start   <= frame_tick;
    end
  end

  // Result RAM has no reset; contents are undefined until the first frame
  always_ff @(posedge sys_clk) begin
    if (meas_we) begin
      ram[meas_addr] <= meas_data;
    end
    if (frame_tick) begin
      ram[`AMBIENT_WORD] <= ambient_temperature_result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Bit engine
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg   <= ir_link_pkg::S_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      sda_oe_reg  <= 1'b0;
      rw_reg      <= 1'b0;
      sel_reg     <= 1'b0;
      mack_reg    <= 1'b0;
    end else if (stop_cond | !startup_done) begin
      state_reg  <= ir_link_pkg::S_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg   <= ir_link_pkg::S_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ir_link_pkg::S_ADDR, ir_link_pkg::S_RX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_in) begin
            if (state_reg == ir_link_pkg::S_RX | addr_hit) begin
              state_reg  <= ir_link_pkg::S_ACK;
              sda_oe_reg <= 1'b1;
            end else begin
              state_reg <= ir_link_pkg::S_IDLE;
            end
            if (state_reg == ir_link_pkg::S_ADDR) begin
              rw_reg  <= shift_reg[0];
              sel_reg <= hit_array;
            end
          end
        end
        ir_link_pkg::S_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg  <= ir_link_pkg::S_TX;
              shift_reg  <= tx_byte;
              sda_oe_reg <= ~tx_byte[7];
            end else begin
              state_reg  <= ir_link_pkg::S_RX;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ir_link_pkg::S_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_in) begin
            state_reg  <= ir_link_pkg::S_MACK;
            sda_oe_reg <= 1'b0;
          end else if (scl_fall) begin
            shift_reg  <= {shift_reg[6:0], 1'b0};
            sda_oe_reg <= ~shift_reg[6];
          end
        end
        ir_link_pkg::S_MACK: begin
          if (scl_rise) begin
            mack_reg <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (mack_reg) begin
              state_reg  <= ir_link_pkg::S_TX;
              shift_reg  <= tx_byte;
              sda_oe_reg <= ~tx_byte[7];
            end else begin
              state_reg <= ir_link_pkg::S_IDLE;
            end
          end
        end
        default: begin
          state_reg  <= ir_link_pkg::S_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Command decoder; read parameters survive a repeated start
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idx_reg               <= 3'h0;
      opcode_reg            <= 8'h00;
      chk_reg               <= 8'h00;
      ptr_reg               <= 8'h00;
      step_reg              <= 8'h00;
      left_reg              <= 8'h00;
      hi_reg                <= 1'b0;
      frame_setup_word      <= `CFG_RESET;
      oscillator_tune_value <= `TRIM_RESET;
    end else begin
      if (addr_ok & ~shift_reg[0]) begin
        idx_reg <= 3'h0;
      end else if (byte_done) begin
        if (idx_reg != 3'h7) begin
          idx_reg <= idx_reg + 3'h1;
        end
        if (idx_reg == 3'h0) begin
          opcode_reg <= shift_reg;
        end else if (is_read) begin
          if (idx_reg == 3'h1) ptr_reg <= shift_reg;
          if (idx_reg == 3'h2) step_reg <= shift_reg;
          if (idx_reg == 3'h3) begin
            left_reg <= shift_reg;
            hi_reg   <= 1'b0;
          end
        end else if (idx_reg == 3'h1 | idx_reg == 3'h3) begin
          chk_reg <= shift_reg;
        end
      end
      // Each half is checked alone; a bad pair keeps the old half
      if (pair_end & is_cfg) begin
        if (set_lo) frame_setup_word[7:0] <= shift_reg;
        else frame_setup_word[15:8] <= shift_reg;
      end
      if (pair_end & is_trim) begin
        if (set_lo) oscillator_tune_value[7:0] <= shift_reg;
        else oscillator_tune_value[15:8] <= shift_reg;
      end
      // Words go low byte first; pointer advances after the high byte
      if (tx_load & sel_reg & left_reg != 8'h00) begin
        hi_reg <= ~hi_reg;
        if (hi_reg) begin
          ptr_reg  <= ptr_reg + step_reg;
          left_reg <= left_reg - 8'h01;
        end
      end
    end
  end
endmodule : ir_array_slave

`default_nettype wire

// ---- logic/ir_link_defs.svh ----
// Constants shared by both ends of the pixel-array serial link.
// Assumes a 20 MHz system clock on both ends.
`ifndef IR_LINK_DEFS_SVH
`define IR_LINK_DEFS_SVH

`define SYS_CLK_HZ      20000000
`define STARTUP_MS      5
`define STARTUP_CYC     (`SYS_CLK_HZ / 1000 * `STARTUP_MS)
`define BUS_MAX_BPS     1000000
`define SCL_QUARTER_CYC (`SYS_CLK_HZ / (4 * `BUS_MAX_BPS))
`define FRAME_BASE_CYC  39062

`define ARRAY_ADDR      7'h60
`define STORE_ADDR      7'h50
`define OP_READ         8'h02
`define OP_CFG          8'h03
`define OP_TRIM         8'h04
`define CFG_KEY         8'h55
`define TRIM_KEY        8'hAA
`define IDLE_BYTE       8'hFF

`define CFG_RESET       16'h0000
`define TRIM_RESET      16'h0000
`define RATE_LSB        0
`define RATE_MSB        3
`define AMBIENT_WORD    8'h90
`define CFG_WORD        8'h92
`define TRIM_WORD       8'h93

`define STEP_ROW_END    4'h7
`define STEP_READS      4'h8
`define STEP_RD_STOP    4'h9

`endif

// ---- logic/ir_link_if.sv ----
// Two-wire link between the bus master and the pixel-array slave.
// Open-drain wires are resolved here from the drivers' enables.
`default_nettype none

interface ir_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  wire  scl;
  wire  sda;

  // Pull-up wins unless an enabled driver pulls low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport device (
    input  scl,
    input  sda,
    output s_sda_o,
    output s_sda_oe
  );

  modport host (
    input  scl,
    input  sda,
    output scl_o,
    output scl_oe,
    output m_sda_o,
    output m_sda_oe
  );
endinterface : ir_link_if

`default_nettype wire

// ---- logic/ir_link_pkg.sv ----
// Types shared by both ends of the pixel-array serial link.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package ir_link_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACK  = 3'b010,
    S_RX   = 3'b011,
    S_TX   = 3'b100,
    S_MACK = 3'b101
  } slave_state_t;

  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_RUN  = 1'b1
  } host_state_t;

  typedef enum logic [1:0] {
    K_READ = 2'b00,
    K_CFG  = 2'b01,
    K_TRIM = 2'b10
  } cmd_kind_t;
endpackage : ir_link_pkg

`default_nettype wire

// ---- logic/pin_sync.sv ----
// Two-flop synchroniser for pins arriving from outside sys_clk.
// Assumes the inputs are quasi-static levels.
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Reset to the released level of an open-drain pin
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= '1;
      q        <= '1;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : pin_sync

`default_nettype wire

// ---- verification/ir_link_monitor.sv ----
// Checker for the two-wire link between the master and the array slave.
// Assumes the signals of one ir_link_if and the link's sys_clk and srst.
`default_nettype none

module ir_link_monitor #(
  parameter int unsigned STARTUP_CYC = 200
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] up_reg;

  // Saturates so a long run cannot wrap back into the silent span
  always_ff @(posedge sys_clk) begin
    if (srst) up_reg <= 32'h0000_0000;
    else if (up_reg < STARTUP_CYC) up_reg <= up_reg + 32'h0000_0001;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_high;
    scl [*8];
  endsequence
  // Framing steps hold the clock low for a single quarter only
  sequence s_low;
    !scl [*5];
  endsequence

  property p_open_drain;
    !((scl_oe & scl_o) | (m_sda_oe & m_sda_o) | (s_sda_oe & s_sda_o));
  endproperty
  property p_silent;
    (up_reg < STARTUP_CYC) |-> !s_sda_oe;
  endproperty
  property p_slave_change;
    $changed(s_sda_oe) |-> !scl;
  endproperty
  property p_hold;
    $rose(scl) |-> $stable(s_sda_oe) [*8];
  endproperty
  property p_scl_high;
    $rose(scl) |-> s_high;
  endproperty
  property p_scl_low;
    $fell(scl) |-> s_low;
  endproperty
  property p_start;
    scl && $fell(sda) |-> $past(scl) && m_sda_oe && !s_sda_oe;
  endproperty
  property p_stop;
    scl && $rose(sda) |-> $past(scl) && !m_sda_oe && !s_sda_oe;
  endproperty

  a_open_drain: assert property (p_open_drain) else $error("Link line driven high");
  a_silent: assert property (p_silent) else $error("Slave drove data during startup");
  a_slave_change: assert property (p_slave_change) else $error("Slave data moved with clock high");
  a_hold: assert property (p_hold) else $error("Slave data not held over clock high");
  a_scl_high: assert property (p_scl_high) else $error("Clock high phase too short");
  a_scl_low: assert property (p_scl_low) else $error("Clock low phase too short");
  a_start: assert property (p_start) else $error("Bad start condition");
  a_stop: assert property (p_stop) else $error("Bad stop condition");
endmodule : ir_link_monitor

`default_nettype wire

// ---- verification/tb_top.sv ----
// Bench: two master/slave pairs; the second master talks to the second address.
// Assumes the logic/ files compiled first and logic/ on the include path.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned STARTUP = 200;
  localparam logic [7:0] RA [5] = '{8'h00, 8'h02, 8'h0C, 8'h05, 8'h3F};
  localparam logic [7:0] RS [5] = '{8'h01, 8'h04, 8'h01, 8'h00, 8'hF8};
  localparam logic [7:0] RC [5] = '{8'h40, 8'h10, 8'h04, 8'h01, 8'h03};

  logic                   sys_clk, srst, meas_we, fs, sd, sd1;
  logic [1:0]             cv, rdy, dn, rv, nk;
  logic [15:0]            rw [2];
  logic [7:0]             meas_addr, a_in, s_in, c_in;
  logic [15:0]            meas_data, amb, w_in, cfg0, trim0, cfg1, trim1;
  ir_link_pkg::cmd_kind_t k_in;
  logic [15:0]            q [$];
  int                     n_fail, n_tests, i, n;

  ir_link_if link0 ();
  ir_link_if link1 ();

  ir_array_slave #(.STARTUP_CYC(STARTUP), .FRAME_BASE_CYC(50)) ir_array_slave_i (
    .sys_clk(sys_clk), .srst(srst), .link(link0.device), .meas_we(meas_we), .meas_addr(meas_addr),
    .meas_data(meas_data), .ambient_temperature_result(amb), .frame_start(fs), .startup_done(sd),
    .frame_setup_word(cfg0), .oscillator_tune_value(trim0));
  ir_array_slave #(.STARTUP_CYC(STARTUP), .FRAME_BASE_CYC(50)) ir_array_slave_i2 (
    .sys_clk(sys_clk), .srst(srst), .link(link1.device), .meas_we(meas_we), .meas_addr(meas_addr),
    .meas_data(meas_data), .ambient_temperature_result(amb), .frame_start(), .startup_done(sd1),
    .frame_setup_word(cfg1), .oscillator_tune_value(trim1));
  ir_array_master #(.QUARTER_CYC(5)) ir_array_master_i (
    .sys_clk(sys_clk), .srst(srst), .link(link0.host), .cmd_valid(cv[0]), .cmd_kind(k_in), .cmd_word(w_in),
    .cmd_start_addr(a_in), .cmd_step(s_in), .cmd_count(c_in), .cmd_ready(rdy[0]), .rd_valid(rv[0]),
    .rd_word(rw[0]), .done(dn[0]), .nack_seen(nk[0]));
  ir_array_master #(.QUARTER_CYC(5), .ARRAY_ADDR(7'h50)) ir_array_master_i2 (
    .sys_clk(sys_clk), .srst(srst), .link(link1.host), .cmd_valid(cv[1]), .cmd_kind(k_in), .cmd_word(w_in),
    .cmd_start_addr(a_in), .cmd_step(s_in), .cmd_count(c_in), .cmd_ready(rdy[1]), .rd_valid(rv[1]),
    .rd_word(rw[1]), .done(dn[1]), .nack_seen(nk[1]));
  ir_link_monitor #(.STARTUP_CYC(STARTUP)) ir_link_monitor_i (
    .sys_clk(sys_clk), .srst(srst), .scl_o(link0.scl_o), .scl_oe(link0.scl_oe), .m_sda_o(link0.m_sda_o),
    .m_sda_oe(link0.m_sda_oe), .s_sda_o(link0.s_sda_o), .s_sda_oe(link0.s_sda_oe), .scl(link0.scl),
    .sda(link0.sda));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Compares %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // One command on master m; read words land in q
  task automatic run(input int m, input ir_link_pkg::cmd_kind_t k, input logic [15:0] w,
                     input logic [7:0] a, input logic [7:0] s, input logic [7:0] c);
    int j;
    q.delete();
    @(negedge sys_clk);
    k_in = k; w_in = w; a_in = a; s_in = s; c_in = c; cv[m] = 1'b1;
    @(negedge sys_clk);
    cv[m] = 1'b0;
    for (j = 0; j < 30000; j++) begin
      @(posedge sys_clk); #1;
      if (rv[m] === 1'b1) q.push_back(rw[m]);
      if (dn[m] === 1'b1) break;
    end
    if (j == 30000) begin
      n_fail++;
      end_of_test();
    end
    chk({15'h0000, rdy[m]}, 16'h0001);
  endtask : run

  task automatic rd(input logic [7:0] a, input logic [7:0] s, input logic [7:0] c);
    logic [7:0] p;
    int         j;
    run(0, ir_link_pkg::K_READ, 16'h0000, a, s, c);
    chk(16'(q.size()), {8'h00, c});
    p = a;
    for (j = 0; j < c; j++) begin
      chk(q[j], 16'hA000 | {8'h00, p});
      p = p + s;
    end
  endtask : rd

  initial begin
    srst = 1'b1; cv = 2'b00; meas_we = 1'b0; meas_addr = 8'h00; meas_data = 16'h0000; amb = 16'h1357;
    k_in = ir_link_pkg::K_READ; w_in = 16'h0000; a_in = 8'h00; s_in = 8'h00; c_in = 8'h00;
    n_fail = 0; n_tests = 0;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    run(0, ir_link_pkg::K_CFG, 16'h00F1, 8'h00, 8'h00, 8'h00);
    chk({15'h0000, nk[0]}, 16'h0001);
    chk(cfg0, 16'h0000);
    for (i = 0; i < 1000 && sd !== 1'b1; i++) @(posedge sys_clk);
    chk({15'h0000, sd}, 16'h0001);
    chk({15'h0000, sd1}, 16'h0001);
    if (sd !== 1'b1) end_of_test();
    $display("Test startup finished");
    for (i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      meas_we = 1'b1; meas_addr = 8'(i); meas_data = 16'hA000 | 16'(i);
    end
    @(negedge sys_clk);
    meas_we = 1'b0;
    for (i = 0; i < 5; i++) rd(RA[i], RS[i], RC[i]);
    $display("Test strided reads finished");
    run(0, ir_link_pkg::K_CFG, 16'h5A32, 8'h00, 8'h00, 8'h00);
    chk({15'h0000, nk[0]}, 16'h0000);
    chk(cfg0, 16'h5A32);
    run(0, ir_link_pkg::K_TRIM, 16'hBEEF, 8'h00, 8'h00, 8'h00);
    chk(trim0, 16'hBEEF);
    run(0, ir_link_pkg::K_READ, 16'h0000, 8'h92, 8'h01, 8'h02);
    chk(q[0], 16'h5A32);
    chk(q[1], 16'hBEEF);
    $display("Test checked writes finished");
    for (n = 0; n < 5000; n++) begin
      @(posedge sys_clk); #1;
      if (fs === 1'b1) break;
    end
    if (n == 5000) begin
      n_fail++;
      end_of_test();
    end
    for (n = 1; n < 5000; n++) begin
      @(posedge sys_clk); #1;
      if (fs === 1'b1) break;
    end
    chk(16'(n), 16'h00C8);
    run(0, ir_link_pkg::K_READ, 16'h0000, 8'h90, 8'h00, 8'h01);
    chk(q[0], 16'h1357);
    $display("Test frame refresh finished");
    run(1, ir_link_pkg::K_CFG, 16'h1111, 8'h00, 8'h00, 8'h00);
    chk({15'h0000, nk[1]}, 16'h0000);
    chk(cfg1, 16'h0000);
    chk(trim1, 16'h0000);
    run(1, ir_link_pkg::K_READ, 16'h0000, 8'h00, 8'h00, 8'h01);
    chk(q[0], 16'hFFFF);
    $display("Test second address finished");
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
